// File: design/ccr_pkg.sv
// package: constants and carrier types for the cpu context register model
package ccr_pkg;
  localparam int DATA_W   = 16;
  localparam int NUM_WREG = 16;
  localparam int NUM_ALT  = 4;
  localparam int CTX_W    = 3;
  localparam int PC_W     = 23;
  localparam int INSTR_W  = 24;
  localparam int ACC_W    = 40;
  localparam int DADDR_W  = 16;
  localparam int PADDR_W  = 23;
  localparam int IPL_W    = 3;

  localparam logic [15:0] ADDR_WREG_BASE  = 16'h0000;
  localparam logic [15:0] ADDR_WREG_LAST  = 16'h001e;
  localparam logic [15:0] ADDR_ACCUMULATOR_A_L     = 16'h0022;
  localparam logic [15:0] ADDR_ACCUMULATOR_A_H     = 16'h0024;
  localparam logic [15:0] ADDR_ACCUMULATOR_A_U     = 16'h0026;
  localparam logic [15:0] ADDR_ACCUMULATOR_B_L     = 16'h0028;
  localparam logic [15:0] ADDR_ACCUMULATOR_B_H     = 16'h002a;
  localparam logic [15:0] ADDR_ACCUMULATOR_B_U     = 16'h002c;
  localparam logic [15:0] ADDR_PC_L       = 16'h002e;
  localparam logic [15:0] ADDR_PC_H       = 16'h0030;
  localparam logic [15:0] ADDR_LOOP_STL   = 16'h0036;
  localparam logic [15:0] ADDR_LOOP_STH   = 16'h0038;
  localparam logic [15:0] ADDR_XMOD_ST    = 16'h0046;
  localparam logic [15:0] ADDR_XMOD_END   = 16'h0048;
  localparam logic [15:0] ADDR_YMOD_ST    = 16'h004a;
  localparam logic [15:0] ADDR_YMOD_END   = 16'h004c;
  localparam logic [15:0] ADDR_MODCFG     = 16'h004e;
  localparam logic [15:0] ADDR_BITREV     = 16'h0050;
  localparam logic [15:0] ADDR_PSVPAG     = 16'h0052;
  localparam logic [15:0] ADDR_ALTCFG     = 16'h0054;
  localparam logic [15:0] ADDR_CTXSTAT    = 16'h0056;

  // 3-bit level field per set, on a 4-bit pitch
  localparam int ALTCFG_FLD_W = 4;
  localparam int CTXSTAT_CUR_LSB = 0;
  localparam int CTXSTAT_MAN_LSB = 8;
  localparam int MODCFG_XEN_BIT = 15;
  localparam int MODCFG_YEN_BIT = 14;
  localparam int MODCFG_BREN_BIT = 13;

  localparam int PSV_PAGE_W = 8;
  localparam logic [15:0] PSV_BASE = 16'h8000;
  localparam int PSV_OFS_W = 14;

  localparam logic [CTX_W-1:0] CTX_PRIMARY = 3'h0;
  localparam logic [IPL_W-1:0] IPL_MIN_ALT = 3'h1;
  localparam logic [IPL_W-1:0] IPL_MAX_ALT = 3'h6;
  localparam logic [PC_W-1:0]  PC_RESET    = 23'h000000;
  localparam logic [PC_W-1:0]  PC_STEP     = 23'h000002;
  localparam int CTX_STACK_D  = 8;

  typedef enum logic [2:0] {
    AM_INHERENT, AM_RELATIVE, AM_LITERAL, AM_MEM_DIRECT, AM_REG_DIRECT, AM_REG_INDIRECT
  } ccr_amode_e;

  typedef enum logic [1:0] {EX_SINGLE, EX_FLOW, EX_MULTI} ccr_exec_e;

  typedef struct packed {
    logic                 valid;
    logic [INSTR_W-1:0]   word;
    ccr_exec_e            kind;
    logic [1:0]           extraCycles;
    logic                 ctxSwap;
    logic [CTX_W-1:0]     ctxSel;
    logic                 flowTaken;
    logic [PC_W-1:0]      flowTarget;
  } ccr_instr_s;

  typedef struct packed {
    logic                 wrEn;
    logic [3:0]           wrIdx;
    logic [DATA_W-1:0]    wrData;
    logic [3:0]           rdIdxA;
    logic [3:0]           rdIdxB;
  } ccr_wport_s;

  typedef struct packed {
    logic                 en;
    logic                 useY;
    logic                 modulo;
    logic                 bitRev;
    logic [DATA_W-1:0]    base;
    logic [DATA_W-1:0]    offset;
  } ccr_agu_req_s;

  typedef struct packed {
    logic                 en;
    logic                 wr;
    logic [DADDR_W-1:0]   addr;
    logic [DATA_W-1:0]    wdata;
  } ccr_mm_req_s;
endpackage : ccr_pkg

// File: design/ccr_agu.sv
// address generator: registered effective address plus linear, modulo or bit-reversed next pointer
`timescale 1ns/1ns
`default_nettype none
module ccr_agu (
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire ccr_pkg::ccr_agu_req_s        req,
  input  wire logic [ccr_pkg::DATA_W-1:0]   modStart,
  input  wire logic [ccr_pkg::DATA_W-1:0]   modEnd,
  input  wire logic                         modEn,
  input  wire logic                         bitRevEn,
  input  wire logic [ccr_pkg::DATA_W-1:0]   bitRevMod,
  output logic      [ccr_pkg::DATA_W-1:0]   effAddr,
  output logic      [ccr_pkg::DATA_W-1:0]   nextPtr
);
  logic [ccr_pkg::DATA_W-1:0] linear;
  logic [ccr_pkg::DATA_W-1:0] wrapped;
  logic [ccr_pkg::DATA_W-1:0] reversed;
  logic [ccr_pkg::DATA_W-1:0] addrReg;
  logic [ccr_pkg::DATA_W-1:0] ptrReg;

  assign linear = ccr_pkg::DATA_W'(req.base + req.offset);

  // circular buffer wraps back to the start once the end word is passed
  always_comb begin
    wrapped = linear;
    if (linear > modEnd) begin
      wrapped = ccr_pkg::DATA_W'(modStart + (linear - modEnd) - 16'h0002);
    end else if (linear < modStart) begin
      wrapped = ccr_pkg::DATA_W'(modEnd - (modStart - linear) + 16'h0002);
    end
  end

  // reverse-carry add: reorders radix-2 fft data without a lookup table
  always_comb begin
    logic [ccr_pkg::DATA_W-1:0] revBase;
    logic [ccr_pkg::DATA_W-1:0] revMod;
    revBase  = '0;
    revMod   = '0;
    for (int i = 0; i < ccr_pkg::DATA_W; i++) begin
      revBase[i] = req.base[ccr_pkg::DATA_W-1-i];
      revMod[i]  = bitRevMod[ccr_pkg::DATA_W-1-i];
    end
    revBase  = ccr_pkg::DATA_W'(revBase + revMod);
    reversed = '0;
    for (int i = 0; i < ccr_pkg::DATA_W; i++) begin
      reversed[i] = revBase[ccr_pkg::DATA_W-1-i];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addrReg <= '0;
      ptrReg  <= '0;
    end else if (req.en) begin
      addrReg <= req.base;
      if (req.bitRev && bitRevEn) begin
        ptrReg <= reversed;
      end else if (req.modulo && modEn) begin
        ptrReg <= wrapped;
      end else begin
        ptrReg <= linear;
      end
    end
  end

  assign effAddr = addrReg;
  assign nextPtr = ptrReg;
endmodule // ccr_agu
`default_nettype wire

// File: design/ccr_core_regs.sv
// cpu programmer's model: working registers, alternate contexts, pc, agus
// Function
// - sixteen 16-bit working registers usable as data, pointer or offset.
// - working register fifteen is the stack pointer for interrupts and calls.
// - four persistent alternate sets duplicate registers zero through fourteen.
// - each alternate set maps to one priority level 1-6 via 3-bit field.
// - context swap instruction selects an alternate set manually.
// - context status reports current set and last manual set, 3 bits each.
// - mapped accesses to registers 0-14 hit the active context copy.
// - program counter is 23 bits, addressing 4M words of 24 bits.
// - instruction words are 24 bits with variable-length opcode.
// - one instruction per cycle except flow, double move, window, table.
// - loop and repeat run without overhead and accept interrupts anywhere.
// - 32K-word data space split into X and Y, each with own generator.
// - general instructions access data only through the X generator, in any of its modes.
// - dual-operand instructions fetch through X and Y generators at once.
// - upper 32 Kbytes always map to program memory at 16K-word pages; there is no enable bit.
// - modulo addressing on X and Y; X modulo works with any instruction.
// - X generator supports bit-reversed addressing for radix-2 FFT.
// - six addressing modes: inherent, relative, literal, direct, reg, indirect.
// - every model register is memory-mapped and readable; all but loop start and context status are writable.
// - loop start address high and low registers are read-only.
// - two 40-bit accumulators plus four alternate accumulator copies.
`timescale 1ns/1ns
`default_nettype none
module ccr_core_regs (
  input  wire logic                           core_clk,
  input  wire logic                           resetn,
  input  wire ccr_pkg::ccr_instr_s            instr,
  input  wire ccr_pkg::ccr_wport_s            wport,
  input  wire ccr_pkg::ccr_mm_req_s           mmReq,
  input  wire ccr_pkg::ccr_agu_req_s          xReq,
  input  wire ccr_pkg::ccr_agu_req_s          yReq,
  input  wire ccr_pkg::ccr_amode_e            addrMode,
  input  wire logic                           dualFetch,
  input  wire logic                           irqEntry,
  input  wire logic [ccr_pkg::IPL_W-1:0]      irqLevel,
  input  wire logic                           irqReturn,
  input  wire logic                           loopStartLoad,
  input  wire logic [ccr_pkg::PC_W-1:0]       loopStartAddr,
  input  wire logic                           accWrEn,
  input  wire logic                           accSel,
  input  wire logic [ccr_pkg::ACC_W-1:0]      accWrData,
  output logic      [ccr_pkg::DATA_W-1:0]     rdDataA,
  output logic      [ccr_pkg::DATA_W-1:0]     rdDataB,
  output logic      [ccr_pkg::DATA_W-1:0]     mmRdData,
  output logic      [ccr_pkg::DATA_W-1:0]     stackPointer,
  output logic      [ccr_pkg::PC_W-1:0]       programCounter,
  output logic                                instrStall,
  output logic      [ccr_pkg::DADDR_W-1:0]    xAddr,
  output logic      [ccr_pkg::DADDR_W-1:0]    yAddr,
  output logic                                yAddrValid,
  output logic                                progWindowHit,
  output logic      [ccr_pkg::PADDR_W-1:0]    progWindowAddr,
  output logic      [ccr_pkg::DATA_W-1:0]     xNextPtr,
  output logic      [ccr_pkg::DATA_W-1:0]     yNextPtr,
  output logic      [ccr_pkg::CTX_W-1:0]      currentContextIndex,
  output logic      [ccr_pkg::CTX_W-1:0]      manualContextIndex,
  output logic      [ccr_pkg::ACC_W-1:0]      accumulatorA,
  output logic      [ccr_pkg::ACC_W-1:0]      accumulatorB
);
  localparam int NCTX = ccr_pkg::NUM_ALT + 1;
  localparam int NLOW = ccr_pkg::NUM_WREG - 1;

  // context 0 is the primary set, 1..4 the alternates
  logic [ccr_pkg::DATA_W-1:0] wregBank_reg [NCTX][NLOW];
  logic [ccr_pkg::DATA_W-1:0] stack_pointer_reg;
  logic [ccr_pkg::ACC_W-1:0]  accumulator_a_reg [NCTX];
  logic [ccr_pkg::ACC_W-1:0]  accumulator_b_reg [NCTX];
  logic [ccr_pkg::PC_W-1:0]   program_counter_reg;
  logic [ccr_pkg::PC_W-1:0]   loopStart_reg;
  logic [ccr_pkg::CTX_W-1:0]  curCtx_reg;
  logic [ccr_pkg::CTX_W-1:0]  manCtx_reg;
  logic [ccr_pkg::DATA_W-1:0] altCfg_reg;
  logic [ccr_pkg::DATA_W-1:0] xModSt_reg;
  logic [ccr_pkg::DATA_W-1:0] xModEnd_reg;
  logic [ccr_pkg::DATA_W-1:0] yModSt_reg;
  logic [ccr_pkg::DATA_W-1:0] yModEnd_reg;
  logic [ccr_pkg::DATA_W-1:0] modCfg_reg;
  logic [ccr_pkg::DATA_W-1:0] bitRev_reg;
  logic [ccr_pkg::PSV_PAGE_W-1:0] psvPage_reg;
  logic [1:0]                 stallCnt_reg;
  logic [ccr_pkg::CTX_W-1:0]  ctxStack_reg [ccr_pkg::CTX_STACK_D];
  logic [2:0]                 ctxDepth_reg;
  logic [ccr_pkg::CTX_W-1:0]  irqCtx;
  logic                       irqHasAlt;
  logic                       mmWr;
  logic [3:0]                 mmIdx;
  logic                       mmIsWreg;
  logic [ccr_pkg::DATA_W-1:0] accWord;
  logic [ccr_pkg::DATA_W-1:0] xEff;
  logic [ccr_pkg::DATA_W-1:0] yEff;
  ccr_pkg::ccr_agu_req_s      xReqEff;

  assign mmWr     = mmReq.en && mmReq.wr;
  assign mmIsWreg = mmReq.addr <= ccr_pkg::ADDR_WREG_LAST;
  assign mmIdx    = mmReq.addr[4:1];

  // find the alternate set assigned to the arriving priority level
  always_comb begin
    irqCtx    = ccr_pkg::CTX_PRIMARY;
    irqHasAlt = 1'b0;
    for (int s = ccr_pkg::NUM_ALT; s >= 1; s--) begin
      if (irqLevel >= ccr_pkg::IPL_MIN_ALT && irqLevel <= ccr_pkg::IPL_MAX_ALT &&
          altCfg_reg[(s-1)*ccr_pkg::ALTCFG_FLD_W +: ccr_pkg::CTX_W] == irqLevel) begin
        irqCtx    = ccr_pkg::CTX_W'(s);
        irqHasAlt = 1'b1;
      end
    end
  end

  // context selection: swap instruction, interrupt entry and return
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      curCtx_reg   <= ccr_pkg::CTX_PRIMARY;
      manCtx_reg   <= ccr_pkg::CTX_PRIMARY;
      ctxDepth_reg <= '0;
      for (int i = 0; i < ccr_pkg::CTX_STACK_D; i++) begin
        ctxStack_reg[i] <= ccr_pkg::CTX_PRIMARY;
      end
    end else if (irqEntry) begin
      // entry pushes even without an alt set so return pairs stay balanced
      ctxStack_reg[ctxDepth_reg] <= curCtx_reg;
      ctxDepth_reg <= ctxDepth_reg + 3'h1;
      if (irqHasAlt) begin
        curCtx_reg <= irqCtx;
      end
    end else if (irqReturn && ctxDepth_reg != '0) begin
      curCtx_reg   <= ctxStack_reg[ctxDepth_reg - 3'h1];
      ctxDepth_reg <= ctxDepth_reg - 3'h1;
    end else if (instr.valid && instr.ctxSwap && instr.ctxSel <= ccr_pkg::CTX_W'(ccr_pkg::NUM_ALT)) begin
      curCtx_reg <= instr.ctxSel;
      manCtx_reg <= instr.ctxSel;
    end
  end

  // working register banks; only the active copy of 0..14 is written
  generate
    for (genvar c = 0; c < NCTX; c++) begin : g_ctx
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          for (int r = 0; r < NLOW; r++) begin
            wregBank_reg[c][r] <= '0;
          end
        end else if (curCtx_reg == ccr_pkg::CTX_W'(c)) begin
          if (mmWr && mmIsWreg && mmIdx != 4'hf) begin
            wregBank_reg[c][mmIdx] <= mmReq.wdata;
          end else if (wport.wrEn && wport.wrIdx != 4'hf) begin
            wregBank_reg[c][wport.wrIdx] <= wport.wrData;
          end
        end
      end
    end
  endgenerate

  // stack pointer is shared by every context
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stack_pointer_reg <= '0;
    end else if (mmWr && mmIsWreg && mmIdx == 4'hf) begin
      stack_pointer_reg <= mmReq.wdata;
    end else if (wport.wrEn && wport.wrIdx == 4'hf) begin
      stack_pointer_reg <= wport.wrData;
    end
  end

  function automatic logic [ccr_pkg::DATA_W-1:0] wread(input logic [3:0] idx);
    if (idx == 4'hf) begin
      return stack_pointer_reg;
    end
    return wregBank_reg[curCtx_reg][idx];
  endfunction

  assign rdDataA = wread(wport.rdIdxA);
  assign rdDataB = wread(wport.rdIdxB);

  // accumulators follow the context so handlers keep their own copies
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < NCTX; c++) begin
        accumulator_a_reg[c] <= '0;
        accumulator_b_reg[c] <= '0;
      end
    end else if (accWrEn) begin
      if (accSel) begin
        accumulator_b_reg[curCtx_reg] <= accWrData;
      end else begin
        accumulator_a_reg[curCtx_reg] <= accWrData;
      end
    end else if (mmWr) begin
      case (mmReq.addr)
        ccr_pkg::ADDR_ACCUMULATOR_A_L: accumulator_a_reg[curCtx_reg][15:0]  <= mmReq.wdata;
        ccr_pkg::ADDR_ACCUMULATOR_A_H: accumulator_a_reg[curCtx_reg][31:16] <= mmReq.wdata;
        ccr_pkg::ADDR_ACCUMULATOR_A_U: accumulator_a_reg[curCtx_reg][39:32] <= mmReq.wdata[7:0];
        ccr_pkg::ADDR_ACCUMULATOR_B_L: accumulator_b_reg[curCtx_reg][15:0]  <= mmReq.wdata;
        ccr_pkg::ADDR_ACCUMULATOR_B_H: accumulator_b_reg[curCtx_reg][31:16] <= mmReq.wdata;
        ccr_pkg::ADDR_ACCUMULATOR_B_U: accumulator_b_reg[curCtx_reg][39:32] <= mmReq.wdata[7:0];
        default: ;
      endcase
    end
  end

  // program counter; multi-cycle instructions hold it while stalled
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stallCnt_reg <= '0;
    end else if (stallCnt_reg != '0) begin
      stallCnt_reg <= stallCnt_reg - 2'h1;
    end else if (instr.valid && instr.kind != ccr_pkg::EX_SINGLE) begin
      stallCnt_reg <= instr.extraCycles;
    end
  end

  assign instrStall = stallCnt_reg != '0;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      program_counter_reg <= ccr_pkg::PC_RESET;
    end else if (mmWr && mmReq.addr == ccr_pkg::ADDR_PC_L) begin
      program_counter_reg[15:0] <= mmReq.wdata;
    end else if (mmWr && mmReq.addr == ccr_pkg::ADDR_PC_H) begin
      program_counter_reg[22:16] <= mmReq.wdata[6:0];
    end else if (instr.valid && !instrStall) begin
      // 24-bit word consumed whole; opcode decode lives upstream
      if (instr.flowTaken) begin
        program_counter_reg <= instr.flowTarget;
      end else begin
        program_counter_reg <= ccr_pkg::PC_W'(program_counter_reg + ccr_pkg::PC_STEP);
      end
    end
  end

  // loop start is loaded by the loop hardware only; bus writes ignored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      loopStart_reg <= '0;
    end else if (loopStartLoad) begin
      loopStart_reg <= loopStartAddr;
    end
  end

  // addressing and alternate-set configuration registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      altCfg_reg  <= '0;
      xModSt_reg  <= '0;
      xModEnd_reg <= '0;
      yModSt_reg  <= '0;
      yModEnd_reg <= '0;
      modCfg_reg  <= '0;
      bitRev_reg  <= '0;
      psvPage_reg <= '0;
    end else if (mmWr) begin
      case (mmReq.addr)
        ccr_pkg::ADDR_ALTCFG:   altCfg_reg  <= mmReq.wdata;
        ccr_pkg::ADDR_XMOD_ST:  xModSt_reg  <= mmReq.wdata;
        ccr_pkg::ADDR_XMOD_END: xModEnd_reg <= mmReq.wdata;
        ccr_pkg::ADDR_YMOD_ST:  yModSt_reg  <= mmReq.wdata;
        ccr_pkg::ADDR_YMOD_END: yModEnd_reg <= mmReq.wdata;
        ccr_pkg::ADDR_MODCFG:   modCfg_reg  <= mmReq.wdata;
        ccr_pkg::ADDR_BITREV:   bitRev_reg  <= mmReq.wdata;
        ccr_pkg::ADDR_PSVPAG:   psvPage_reg <= mmReq.wdata[ccr_pkg::PSV_PAGE_W-1:0];
        default: ;
      endcase
    end
  end

  // memory-mapped read mux
  always_comb begin
    accWord = '0;
    case (mmReq.addr)
      ccr_pkg::ADDR_ACCUMULATOR_A_L:   accWord = accumulator_a_reg[curCtx_reg][15:0];
      ccr_pkg::ADDR_ACCUMULATOR_A_H:   accWord = accumulator_a_reg[curCtx_reg][31:16];
      ccr_pkg::ADDR_ACCUMULATOR_A_U:   accWord = {8'h00, accumulator_a_reg[curCtx_reg][39:32]};
      ccr_pkg::ADDR_ACCUMULATOR_B_L:   accWord = accumulator_b_reg[curCtx_reg][15:0];
      ccr_pkg::ADDR_ACCUMULATOR_B_H:   accWord = accumulator_b_reg[curCtx_reg][31:16];
      ccr_pkg::ADDR_ACCUMULATOR_B_U:   accWord = {8'h00, accumulator_b_reg[curCtx_reg][39:32]};
      ccr_pkg::ADDR_PC_L:     accWord = program_counter_reg[15:0];
      ccr_pkg::ADDR_PC_H:     accWord = {9'h000, program_counter_reg[22:16]};
      ccr_pkg::ADDR_LOOP_STL: accWord = loopStart_reg[15:0];
      ccr_pkg::ADDR_LOOP_STH: accWord = {9'h000, loopStart_reg[22:16]};
      ccr_pkg::ADDR_XMOD_ST:  accWord = xModSt_reg;
      ccr_pkg::ADDR_XMOD_END: accWord = xModEnd_reg;
      ccr_pkg::ADDR_YMOD_ST:  accWord = yModSt_reg;
      ccr_pkg::ADDR_YMOD_END: accWord = yModEnd_reg;
      ccr_pkg::ADDR_MODCFG:   accWord = modCfg_reg;
      ccr_pkg::ADDR_BITREV:   accWord = bitRev_reg;
      ccr_pkg::ADDR_PSVPAG:   accWord = {8'h00, psvPage_reg};
      ccr_pkg::ADDR_ALTCFG:   accWord = altCfg_reg;
      ccr_pkg::ADDR_CTXSTAT:  accWord = {5'h00, manCtx_reg, 5'h00, curCtx_reg};
      default:                accWord = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mmRdData <= '0;
    end else if (mmReq.en && !mmReq.wr) begin
      mmRdData <= mmIsWreg ? wread(mmIdx) : accWord;
    end
  end

  // effective address from the selected mode; inherent, literal and register direct give none
  always_comb begin
    xReqEff = xReq;
    case (addrMode)
      ccr_pkg::AM_REG_INDIRECT: xReqEff.en = xReq.en;
      ccr_pkg::AM_MEM_DIRECT:   xReqEff.en = xReq.en;
      ccr_pkg::AM_RELATIVE:     xReqEff.en = xReq.en;
      default:                  xReqEff.en = 1'b0;
    endcase
  end

  // general instructions only ever drive the X generator
  ccr_agu u_xagu (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .req       (xReqEff),
    .modStart  (xModSt_reg),
    .modEnd    (xModEnd_reg),
    .modEn     (modCfg_reg[ccr_pkg::MODCFG_XEN_BIT]),
    .bitRevEn  (modCfg_reg[ccr_pkg::MODCFG_BREN_BIT]),
    .bitRevMod (bitRev_reg),
    .effAddr   (xEff),
    .nextPtr   (xNextPtr)
  );

  // Y generator has modulo but no bit reversal
  ccr_agu u_yagu (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .req       (yReq),
    .modStart  (yModSt_reg),
    .modEnd    (yModEnd_reg),
    .modEn     (modCfg_reg[ccr_pkg::MODCFG_YEN_BIT]),
    .bitRevEn  (1'b0),
    .bitRevMod (bitRev_reg),
    .effAddr   (yEff),
    .nextPtr   (yNextPtr)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      yAddrValid <= 1'b0;
    end else begin
      yAddrValid <= dualFetch && yReq.en;
    end
  end

  assign xAddr = xEff;
  assign yAddr = yEff;

  // upper half of data space seen through the program window
  assign progWindowHit  = xEff >= ccr_pkg::PSV_BASE;
  assign progWindowAddr = {1'b0, psvPage_reg, xEff[ccr_pkg::PSV_OFS_W:1]};

  assign stackPointer        = stack_pointer_reg;
  assign programCounter      = program_counter_reg;
  assign currentContextIndex = curCtx_reg;
  assign manualContextIndex  = manCtx_reg;
  assign accumulatorA        = accumulator_a_reg[curCtx_reg];
  assign accumulatorB        = accumulator_b_reg[curCtx_reg];
endmodule // ccr_core_regs
`default_nettype wire

// File: sim/ccr_core_regs_assertions.sv
// checker: port timing of the core register model
`timescale 1ns/1ns
`default_nettype none
module ccr_core_regs_assertions (
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire ccr_pkg::ccr_instr_s  instr,
  input wire ccr_pkg::ccr_wport_s  wport,
  input wire ccr_pkg::ccr_mm_req_s mmReq,
  input wire logic                 irqEntry,
  input wire logic                 irqReturn,
  input wire logic [15:0]          mmRdData,
  input wire logic [15:0]          stackPointer,
  input wire logic [22:0]          programCounter,
  input wire logic                 instrStall,
  input wire logic [2:0]           currentContextIndex,
  input wire logic [2:0]           manualContextIndex
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic mmW, noEv, go;
  assign mmW = mmReq.en && mmReq.wr;
  assign noEv = !irqEntry && !irqReturn;
  // stalled slots excluded: the core may hold fetch there
  assign go = instr.valid && !instrStall;
  chk_pc_step: assert property (go && !instr.flowTaken && instr.kind == ccr_pkg::EX_SINGLE && !mmW
    |=> programCounter == $past(programCounter) + 23'h2) else $error("pc step wrong");
  chk_pc_flow: assert property (go && instr.flowTaken && !mmW
    |=> programCounter == $past(instr.flowTarget)) else $error("flow target not loaded");
  chk_stall_len: assert property (go && instr.kind != ccr_pkg::EX_SINGLE && instr.extraCycles == 2'h2
    |=> instrStall [*2] ##1 !instrStall) else $error("stall length wrong");
  chk_swap_sel: assert property (go && instr.ctxSwap && instr.ctxSel <= 3'h4 && noEv
    |=> currentContextIndex == $past(instr.ctxSel) && manualContextIndex == $past(instr.ctxSel))
    else $error("swap not taken");
  chk_swap_bad: assert property (go && instr.ctxSwap && instr.ctxSel > 3'h4 && noEv
    |=> $stable(currentContextIndex)) else $error("bad swap taken");
  chk_status_rd: assert property (mmReq.en && !mmReq.wr && mmReq.addr == ccr_pkg::ADDR_CTXSTAT
    |=> mmRdData[2:0] == $past(currentContextIndex) && mmRdData[10:8] == $past(manualContextIndex))
    else $error("status read wrong");
  chk_sp_write: assert property (wport.wrEn && wport.wrIdx == 4'hf && !mmW
    |=> stackPointer == $past(wport.wrData)) else $error("stack pointer not written");
  chk_unmapped_rd: assert property (mmReq.en && !mmReq.wr && mmReq.addr == 16'h0060
    |=> mmRdData == 16'h0000) else $error("unmapped read not zero");
  cover property (irqEntry);
  cover property (go && instr.ctxSwap);
  cover property (instrStall);
endmodule // ccr_core_regs_assertions
bind ccr_core_regs ccr_core_regs_assertions u_chk (.core_clk, .resetn, .instr, .wport, .mmReq, .irqEntry,
  .irqReturn, .mmRdData, .stackPointer, .programCounter, .instrStall, .currentContextIndex, .manualContextIndex);
`default_nettype wire

// File: sim/ccr_irq_model.sv
// interrupt controller model: turns bench requests into entry and return pulses
`timescale 1ns/1ns
`default_nettype none
module ccr_irq_model (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       reqEnter,
  input  wire logic       reqLeave,
  input  wire logic [2:0] reqLevel,
  output logic            irqEntry,
  output logic            irqReturn,
  output logic [2:0]      irqLevel
);
  // level wanders outside entry so nothing relies on it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) {irqEntry, irqReturn, irqLevel} <= '0;
    else {irqEntry, irqReturn, irqLevel} <= {reqEnter, reqLeave && !reqEnter, reqEnter ? reqLevel : ~irqLevel};
  end
endmodule // ccr_irq_model
`default_nettype wire

// File: sim/testbench.sv
// testbench for the core register model
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk, resetn, reqEnter, reqLeave, loopStartLoad, accWrEn, irqEntry, irqReturn, instrStall;
  logic [2:0] reqLevel, irqLevel, cur, man;
  logic [15:0] mmRdData, stackPointer;
  logic [22:0] programCounter, loopStartAddr;
  logic [39:0] accWrData;
  ccr_pkg::ccr_instr_s instr;
  ccr_pkg::ccr_wport_s wport;
  ccr_pkg::ccr_mm_req_s mmReq;
  int fails, num_checks;
  ccr_core_regs dut (.core_clk, .resetn, .instr, .wport, .mmReq, .xReq('0), .yReq('0), .addrMode(ccr_pkg::AM_INHERENT),
    .dualFetch(1'b0), .irqEntry, .irqLevel, .irqReturn, .loopStartLoad, .loopStartAddr, .accWrEn, .accSel(1'b1),
    .accWrData, .rdDataA(), .rdDataB(), .mmRdData, .stackPointer, .programCounter, .instrStall, .xAddr(), .yAddr(),
    .yAddrValid(), .progWindowHit(), .progWindowAddr(), .xNextPtr(), .yNextPtr(), .currentContextIndex(cur),
    .manualContextIndex(man), .accumulatorA(), .accumulatorB());
  ccr_irq_model u_irq (.core_clk, .resetn, .reqEnter, .reqLeave, .reqLevel, .irqEntry, .irqReturn, .irqLevel);
  initial begin core_clk = 0; forever #50 core_clk = ~core_clk; end
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, exp, seen); end
  endtask
  task automatic mm(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk) mmReq <= {1'b1, wr, a, d};
    @(posedge core_clk) mmReq <= '0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
    mm(1'b0, a, 16'h0);
    chk(n, mmRdData, e);
  endtask
  // extra cycles follow the kind code: flow 1, multi 2
  task automatic issue(input logic sw, input logic [2:0] s, input logic [1:0] k, input logic ft, input logic [22:0] t);
    @(posedge core_clk) instr <= '{1'b1, 24'h0, ccr_pkg::ccr_exec_e'(k), k, sw, s, ft, t};
    @(posedge core_clk) instr <= '0;
    #1;
  endtask
  task automatic irq(input logic ent);
    @(posedge core_clk) begin {reqEnter, reqLeave} <= {ent, !ent}; reqLevel <= 3'h3; end
    @(posedge core_clk) {reqEnter, reqLeave} <= 2'h0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic t_regs;
    mm(1'b1, 16'h0004, 16'h1111);
    rd(16'h0004, 16'h1111, "w2");
    @(posedge core_clk) wport <= {1'b1, 4'hf, 16'h0ffe, 4'hf, 4'h0};
    @(posedge core_clk) wport <= '0;
    #1 chk("sp", stackPointer, 16'h0ffe);
    rd(ccr_pkg::ADDR_WREG_LAST, 16'h0ffe, "w15 mapped");
    rd(16'h0060, 16'h0, "unmapped");
  endtask
  task automatic t_ctx;
    mm(1'b1, ccr_pkg::ADDR_ALTCFG, 16'h0003);
    irq(1'b1);
    chk("ctx entry", cur, 3'h1);
    mm(1'b1, 16'h0004, 16'h2222);
    rd(16'h0004, 16'h2222, "alt w2");
    irq(1'b0);
    chk("ctx ret", cur, 3'h0);
    rd(16'h0004, 16'h1111, "main w2");
  endtask
  task automatic t_swap;
    issue(1'b1, 3'h2, 2'h0, 1'b0, 23'h0);
    chk("swap man", man, 3'h2);
    rd(ccr_pkg::ADDR_CTXSTAT, 16'h0202, "status");
    issue(1'b1, 3'h5, 2'h0, 1'b0, 23'h0);
    chk("bad swap", cur, 3'h2);
    issue(1'b1, 3'h0, 2'h0, 1'b0, 23'h0);
    chk("swap back", cur, 3'h0);
  endtask
  task automatic t_pc;
    issue(1'b0, 3'h0, 2'h1, 1'b1, 23'h7ffffe);
    issue(1'b0, 3'h0, 2'h0, 1'b0, 23'h0);
    chk("pc wrap", programCounter, 23'h0);
    issue(1'b0, 3'h0, 2'h2, 1'b0, 23'h0);
    chk("stall", instrStall, 1'b1);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_ro_acc;
    mm(1'b1, ccr_pkg::ADDR_LOOP_STL, 16'hbeef);
    rd(ccr_pkg::ADDR_LOOP_STL, 16'h0, "loop ro");
    @(posedge core_clk) begin loopStartLoad <= 1'b1; accWrEn <= 1'b1; end
    @(posedge core_clk) begin loopStartLoad <= 1'b0; accWrEn <= 1'b0; end
    rd(ccr_pkg::ADDR_LOOP_STH, 16'h0045, "loop hi");
    rd(ccr_pkg::ADDR_ACCUMULATOR_B_U, 16'h00ab, "acc upper");
  endtask
  initial begin
    {resetn, reqEnter, reqLeave, loopStartLoad, accWrEn, reqLevel} = '0;
    {instr, wport, mmReq, fails, num_checks} = '0;
    loopStartAddr = 23'h456789;
    accWrData = 40'hab12345678;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs; t_ctx; t_swap; t_pc; t_ro_acc;
    finish_test;
  end
  initial begin #2000000; fails++; finish_test; end
endmodule // testbench
`default_nettype wire
